// ### hdl/tocc_channel.sv
// One compare channel: shadowed compare value and output prepare level
`timescale 1ns/1ps
`default_nettype none
module tocc_channel
   import tocc_pkg::*;
(
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic [2:0] mode_in,
   input wire logic [1:0] dir_in,
   input wire logic shadow_in,
   input wire logic fast_in,
   input wire logic clear_en_in,
   input wire logic [CNT_W-1:0] count_in,
   input wire logic count_tick_in,
   input wire logic count_down_in,
   input wire logic [CNT_W-1:0] cmp_wdata_in,
   input wire logic cmp_we_in,
   input wire logic update_in,
   input wire logic trig_edge_in,
   input wire logic ext_trig_in,
   output logic prep_out,
   output logic match_out,
   output logic [CNT_W-1:0] active_cmp_out
);
   logic [CNT_W-1:0] buf_q;
   logic prep_q;
   logic prep_d;
   logic is_pwm;
   logic pwm_level;
   logic cmp_hit;

   always_ff @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         buf_q <= '0;
         active_cmp_out <= '0;
      end
      else
      begin
         if (cmp_we_in)
            buf_q <= cmp_wdata_in;
         // Without shadow the written value takes effect at once
         if (cmp_we_in && !shadow_in)
            active_cmp_out <= cmp_wdata_in;
         else if (update_in && shadow_in)
            active_cmp_out <= buf_q;
      end
   end

   assign cmp_hit = count_tick_in && (count_in == active_cmp_out);
   assign is_pwm = (mode_in == MODE_PWM0) || (mode_in == MODE_PWM1);

   always_comb
   begin
      pwm_level = 1'b0;
      if (!count_down_in)
         pwm_level = (count_in < active_cmp_out);
      else
         pwm_level = !(count_in > active_cmp_out);
      if (mode_in == MODE_PWM1)
         pwm_level = !pwm_level;
      // Fast path: trigger edge forces the compare level at once
      if (fast_in && trig_edge_in)
         pwm_level = (mode_in == MODE_PWM0) ? 1'b0 : 1'b1;
   end

   always_comb
   begin
      prep_d = prep_q;
      case (mode_in)
         MODE_TIMING: prep_d = prep_q;
         MODE_SET: if (cmp_hit) prep_d = 1'b1;
         MODE_CLEAR: if (cmp_hit) prep_d = 1'b0;
         MODE_TOGGLE: if (cmp_hit) prep_d = !prep_q;
         MODE_LOW: prep_d = 1'b0;
         MODE_HIGH: prep_d = 1'b1;
         default: prep_d = pwm_level;
      endcase
      if (clear_en_in && ext_trig_in)
         prep_d = 1'b0;
      if (dir_in != DIR_OUTPUT)
         prep_d = prep_q;
   end

   always_ff @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
         prep_q <= 1'b0;
      else
         prep_q <= prep_d;
   end

   assign prep_out = prep_q;
   assign match_out = cmp_hit;

   a_force_high: assert property (@(posedge clk_in) disable iff (rst_in)
      (mode_in == MODE_HIGH && dir_in == DIR_OUTPUT && !(clear_en_in && ext_trig_in))
      |=> prep_q)
      else $error("Force high not taken");
   a_force_low: assert property (@(posedge clk_in) disable iff (rst_in)
      (mode_in == MODE_LOW && dir_in == DIR_OUTPUT) |=> !prep_q)
      else $error("Force low not taken");
   a_clear_ext: assert property (@(posedge clk_in) disable iff (rst_in)
      (clear_en_in && ext_trig_in && dir_in == DIR_OUTPUT) |=> !prep_q)
      else $error("External clear not taken");
   a_timing_hold: assert property (@(posedge clk_in) disable iff (rst_in)
      (mode_in == MODE_TIMING && !(clear_en_in && ext_trig_in)) |=> $stable(prep_q))
      else $error("Timing mode changed level");
   a_toggle_hit: assert property (@(posedge clk_in) disable iff (rst_in)
      (mode_in == MODE_TOGGLE && cmp_hit && dir_in == DIR_OUTPUT
       && !(clear_en_in && ext_trig_in)) |=> prep_q != $past(prep_q))
      else $error("Toggle on match missing");
   a_shadow_load: assert property (@(posedge clk_in) disable iff (rst_in)
      (update_in && shadow_in && !cmp_we_in) |=> active_cmp_out == $past(buf_q))
      else $error("Shadow not loaded on update");
   a_shadow_hold: assert property (@(posedge clk_in) disable iff (rst_in)
      (shadow_in && !update_in) |=> $stable(active_cmp_out))
      else $error("Active compare moved without update");
   a_pwm0_up: assert property (@(posedge clk_in) disable iff (rst_in)
      (mode_in == MODE_PWM0 && !count_down_in && dir_in == DIR_OUTPUT && !fast_in
       && !clear_en_in) |=> prep_q == $past(count_in < active_cmp_out))
      else $error("PWM0 level wrong");
   a_fast_match: assert property (@(posedge clk_in) disable iff (rst_in)
      (mode_in == MODE_PWM0 && fast_in && trig_edge_in && dir_in == DIR_OUTPUT
       && !(clear_en_in && ext_trig_in)) |=> !prep_q)
      else $error("Fast trigger match not taken");
   c_toggle: cover property (@(posedge clk_in) mode_in == MODE_TOGGLE && cmp_hit);
   c_pwm1: cover property (@(posedge clk_in) mode_in == MODE_PWM1 && $changed(prep_q));
   c_fast: cover property (@(posedge clk_in) fast_in && trig_edge_in && is_pwm);
endmodule : tocc_channel
`default_nettype wire

// ### hdl/tocc_pkg.sv
// Package of register layout and encodings for the two-channel compare control
package tocc_pkg;
   localparam logic [7:0] CTL01_OFFSET = 8'h18;
   localparam logic [31:0] CTL01_RESET = 32'h00000000;
   localparam int CH_STRIDE = 8;
   localparam int DIR_LSB = 0;
   localparam int FAST_BIT = 2;
   localparam int SHADOW_BIT = 3;
   localparam int MODE_LSB = 4;
   localparam int CLEAR_BIT = 7;
   localparam int CNT_W = 16;
   localparam logic [1:0] DIR_OUTPUT = 2'h0;
   localparam logic [1:0] LOCK_FULL = 2'h3;
   typedef enum logic [2:0] {
      MODE_TIMING = 3'b000,
      MODE_SET = 3'b001,
      MODE_CLEAR = 3'b010,
      MODE_TOGGLE = 3'b011,
      MODE_LOW = 3'b100,
      MODE_HIGH = 3'b101,
      MODE_PWM0 = 3'b110,
      MODE_PWM1 = 3'b111
   } tocc_mode_e;
endpackage : tocc_pkg

// ### hdl/tocc_top.sv
// Two-channel output compare control with register port
// Notes on behaviour
// - Direction field chooses output or input source
// - Direction writable only while channel disabled
// - Clear enable with external trigger drives low
// - Output prepare is active high
// - Timing mode holds the output prepare level
// - Match sets, clears or toggles per mode
// - Modes 100/101 force low or high
// - PWM0 high below compare counting up
// - PWM1 is PWM0 inverted
// - PWM level follows comparison changes and, with fast enable, trigger edges
// - Full lock freezes mode and shadow bits while direction is output
// - Shadow buffers compare value until update
// - Fast enable: trigger edge acts as match in PWM modes only
// - Channel 1 fields mirror channel 0 above
// - Channel 0 direction in bits 1:0
`timescale 1ns/1ps
`default_nettype none
module tocc_top
   import tocc_pkg::*;
(
   input wire logic MCLK_IN,
   input wire logic RST_IN,
   input wire logic [7:0] ADDR_IN,
   input wire logic [31:0] WDATA_IN,
   input wire logic WR_IN,
   input wire logic RD_IN,
   output logic [31:0] RDATA_OUT,
   input wire logic [CNT_W-1:0] COUNTER_VALUE_IN,
   input wire logic COUNT_TICK_IN,
   input wire logic COUNT_DOWN_IN,
   input wire logic UPDATE_IN,
   input wire logic TRIGGER_EDGE_IN,
   input wire logic FILTERED_EXTERNAL_TRIGGER_IN,
   input wire logic [1:0] CHANNEL_ENABLE_IN,
   input wire logic [1:0] LOCK_LEVEL_IN,
   input wire logic [1:0] CMP_WE_IN,
   input wire logic [CNT_W-1:0] CMP_WDATA_IN,
   output logic [1:0] OUTPUT_PREPARE_OUT,
   output logic [1:0] COMPARE_MATCH_OUT,
   output logic [2*CNT_W-1:0] ACTIVE_COMPARE_OUT
);
   logic [15:0] ctl_q;
   logic [1:0] ext_sync_q;
   logic [1:0] trig_sync_q;
   logic trig_prev_q;
   logic ext_trig;
   logic trig_edge;
   logic ctl_sel;

   // Pin inputs through two flip-flops before use
   always_ff @(posedge MCLK_IN or posedge RST_IN)
   begin
      if (RST_IN)
      begin
         ext_sync_q <= 2'h0;
         trig_sync_q <= 2'h0;
         trig_prev_q <= 1'b0;
      end
      else
      begin
         ext_sync_q <= {ext_sync_q[0], FILTERED_EXTERNAL_TRIGGER_IN};
         trig_sync_q <= {trig_sync_q[0], TRIGGER_EDGE_IN};
         trig_prev_q <= trig_sync_q[1];
      end
   end
   assign ext_trig = ext_sync_q[1];
   assign trig_edge = trig_sync_q[1] && !trig_prev_q;

   assign ctl_sel = (ADDR_IN == CTL01_OFFSET);

   // Register write with per-field protection
   always_ff @(posedge MCLK_IN or posedge RST_IN)
   begin
      if (RST_IN)
         ctl_q <= CTL01_RESET[15:0];
      else if (WR_IN && ctl_sel)
      begin
         for (int c = 0; c < 2; c++)
         begin
            // Direction may only change while the channel is off
            if (!CHANNEL_ENABLE_IN[c])
               ctl_q[c*CH_STRIDE+DIR_LSB +: 2] <= WDATA_IN[c*CH_STRIDE+DIR_LSB +: 2];
            if (!(LOCK_LEVEL_IN == LOCK_FULL
                  && ctl_q[c*CH_STRIDE+DIR_LSB +: 2] == DIR_OUTPUT))
            begin
               ctl_q[c*CH_STRIDE+MODE_LSB +: 3] <= WDATA_IN[c*CH_STRIDE+MODE_LSB +: 3];
               ctl_q[c*CH_STRIDE+SHADOW_BIT] <= WDATA_IN[c*CH_STRIDE+SHADOW_BIT];
            end
            ctl_q[c*CH_STRIDE+FAST_BIT] <= WDATA_IN[c*CH_STRIDE+FAST_BIT];
            ctl_q[c*CH_STRIDE+CLEAR_BIT] <= WDATA_IN[c*CH_STRIDE+CLEAR_BIT];
         end
      end
   end

   // Read data one cycle later; upper bits and unmapped reads are zero
   always_ff @(posedge MCLK_IN or posedge RST_IN)
   begin
      if (RST_IN)
         RDATA_OUT <= 32'h00000000;
      else if (RD_IN && ctl_sel)
         RDATA_OUT <= {16'h0000, ctl_q};
      else
         RDATA_OUT <= 32'h00000000;
   end

   genvar g;
   generate
      for (g = 0; g < 2; g++)
      begin : g_ch
         // Same field layout per channel, offset by stride
         tocc_channel u_ch (
            .clk_in(MCLK_IN),
            .rst_in(RST_IN),
            .mode_in(ctl_q[g*CH_STRIDE+MODE_LSB +: 3]),
            .dir_in(ctl_q[g*CH_STRIDE+DIR_LSB +: 2]),
            .shadow_in(ctl_q[g*CH_STRIDE+SHADOW_BIT]),
            .fast_in(ctl_q[g*CH_STRIDE+FAST_BIT]),
            .clear_en_in(ctl_q[g*CH_STRIDE+CLEAR_BIT]),
            .count_in(COUNTER_VALUE_IN),
            .count_tick_in(COUNT_TICK_IN),
            .count_down_in(COUNT_DOWN_IN),
            .cmp_wdata_in(CMP_WDATA_IN),
            .cmp_we_in(CMP_WE_IN[g]),
            .update_in(UPDATE_IN),
            .trig_edge_in(trig_edge),
            .ext_trig_in(ext_trig),
            .prep_out(OUTPUT_PREPARE_OUT[g]),
            .match_out(COMPARE_MATCH_OUT[g]),
            .active_cmp_out(ACTIVE_COMPARE_OUT[g*CNT_W +: CNT_W])
         );
      end
   endgenerate

   a_dir_locked: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
      (WR_IN && ctl_sel && CHANNEL_ENABLE_IN[0]) |=> $stable(ctl_q[1:0]))
      else $error("Direction changed while enabled");
   a_mode_locked: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
      (LOCK_LEVEL_IN == LOCK_FULL && ctl_q[1:0] == DIR_OUTPUT) |=> $stable(ctl_q[6:3]))
      else $error("Locked mode field changed");
   a_read_data: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
      (RD_IN && ctl_sel && !WR_IN) |=> RDATA_OUT == {16'h0000, $past(ctl_q)})
      else $error("Read data mismatch");
   c_write: cover property (@(posedge MCLK_IN) WR_IN && ctl_sel);
   c_lock: cover property (@(posedge MCLK_IN) WR_IN && ctl_sel && LOCK_LEVEL_IN == LOCK_FULL);
endmodule : tocc_top
`default_nettype wire

// ### tb/tocc_top_tb.sv
// Self-checking testbench for the two-channel compare control
`timescale 1ns/1ps
`default_nettype none
module tocc_top_tb;
   import tocc_pkg::*;
   typedef struct packed {logic [15:0] ctl; logic [15:0] cnt; logic dn; logic [1:0] exp;} tocc_row_s;
   logic mclk = 1'b0;
   logic rst, wr, rd, tick, dn, upd, trig, ext;
   logic [7:0] addr;
   logic [31:0] wdata, rdata, act, d;
   logic [15:0] cnt, cwd;
   logic [1:0] en, lock, cwe, prep, match;
   int fails = 0;
   int num_checks = 0;
   tocc_row_s rows [13];
   always #10 mclk = ~mclk;
   tocc_top DUT (.MCLK_IN(mclk), .RST_IN(rst), .ADDR_IN(addr), .WDATA_IN(wdata), .WR_IN(wr),
      .RD_IN(rd), .RDATA_OUT(rdata), .COUNTER_VALUE_IN(cnt), .COUNT_TICK_IN(tick),
      .COUNT_DOWN_IN(dn), .UPDATE_IN(upd), .TRIGGER_EDGE_IN(trig),
      .FILTERED_EXTERNAL_TRIGGER_IN(ext), .CHANNEL_ENABLE_IN(en), .LOCK_LEVEL_IN(lock),
      .CMP_WE_IN(cwe), .CMP_WDATA_IN(cwd), .OUTPUT_PREPARE_OUT(prep),
      .COMPARE_MATCH_OUT(match), .ACTIVE_COMPARE_OUT(act));
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         fails++;
         $display("FAIL %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
      @(posedge mclk);
      addr <= a;
      wdata <= v;
      wr <= 1'b1;
      @(posedge mclk);
      wr <= 1'b0;
   endtask : wr_reg
   // Read data stands only in the cycle after the strobe, so sample just past that edge
   task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
      @(posedge mclk);
      addr <= a;
      rd <= 1'b1;
      @(posedge mclk);
      rd <= 1'b0;
      #1 v = rdata;
   endtask : rd_reg
   task automatic step(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask : step
   task automatic cmp_load(input logic [15:0] v);
      @(posedge mclk);
      cwd <= v;
      cwe <= 2'b11;
      @(posedge mclk);
      cwe <= 2'b00;
   endtask : cmp_load
   task end_sim;
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : end_sim
   // Generous bound: the whole sequence needs well under 1000 cycles
   initial
   begin
      #1_000_000;
      fails++;
      end_sim();
   end
   initial
   begin
      rows = '{'{16'h5050, 16'h0000, 1'b0, 2'b11}, '{16'h4040, 16'h0000, 1'b0, 2'b00},
         '{16'h1010, 16'h0010, 1'b0, 2'b11}, '{16'h0000, 16'h0010, 1'b0, 2'b11},
         '{16'h2020, 16'h0010, 1'b0, 2'b00}, '{16'h6868, 16'h0005, 1'b0, 2'b11},
         '{16'h6868, 16'h0010, 1'b0, 2'b00}, '{16'h6868, 16'h0020, 1'b1, 2'b00},
         '{16'h6868, 16'h0008, 1'b1, 2'b11}, '{16'h7878, 16'h0005, 1'b0, 2'b00},
         '{16'h7878, 16'h0020, 1'b0, 2'b11}, '{16'h7878, 16'h0020, 1'b1, 2'b11},
         '{16'h7878, 16'h0008, 1'b1, 2'b00}};
      {rst, wr, rd, dn, upd, trig, ext} = 7'h40;
      tick = 1'b1;
      {addr, wdata, cnt, cwd, en, lock, cwe} = '0;
      repeat (16) @(posedge mclk);
      rst <= 1'b0;
      step(1);
      chk({30'h0, prep}, 32'h0);
      rd_reg(CTL01_OFFSET, d);
      chk(d, CTL01_RESET);
      cmp_load(16'h0010);
      step(2);
      chk(act, 32'h00100010);
      foreach (rows[i])
      begin
         wr_reg(CTL01_OFFSET, {16'h0, rows[i].ctl});
         @(posedge mclk);
         cnt <= rows[i].cnt;
         dn <= rows[i].dn;
         step(3);
         chk({30'h0, prep}, {30'h0, rows[i].exp});
         rd_reg(CTL01_OFFSET, d);
         chk(d, {16'h0, rows[i].ctl});
      end
      // A single matching cycle must toggle exactly once
      wr_reg(CTL01_OFFSET, 32'h3030);
      @(posedge mclk);
      cnt <= 16'h0005;
      dn <= 1'b0;
      @(posedge mclk);
      cnt <= 16'h0010;
      #1 chk({30'h0, match}, 32'h3);
      @(posedge mclk);
      cnt <= 16'h0005;
      step(3);
      chk({30'h0, prep}, 32'h3);
      @(posedge mclk);
      tick <= 1'b0;
      cnt <= 16'h0010;
      #1 chk({30'h0, match}, 32'h0);
      step(3);
      chk({30'h0, prep}, 32'h3);
      @(posedge mclk);
      tick <= 1'b1;
      cnt <= 16'h0005;
      wr_reg(CTL01_OFFSET, 32'hD0D0);
      step(3);
      chk({30'h0, prep}, 32'h3);
      @(posedge mclk);
      ext <= 1'b1;
      step(5);
      chk({30'h0, prep}, 32'h0);
      @(posedge mclk);
      ext <= 1'b0;
      step(5);
      chk({30'h0, prep}, 32'h3);
      // Trigger edge acts as a match for one cycle in PWM0 with fast on
      wr_reg(CTL01_OFFSET, 32'h6C6C);
      @(posedge mclk);
      trig <= 1'b1;
      step(3);
      chk({30'h0, prep}, 32'h0);
      step(1);
      chk({30'h0, prep}, 32'h3);
      @(posedge mclk);
      trig <= 1'b0;
      en <= 2'b10;
      wr_reg(CTL01_OFFSET, 32'h0101);
      rd_reg(CTL01_OFFSET, d);
      chk(d, 32'h0001);
      @(posedge mclk);
      en <= 2'b00;
      wr_reg(CTL01_OFFSET, 32'h5858);
      lock <= 2'b11;
      wr_reg(CTL01_OFFSET, 32'h8181);
      rd_reg(CTL01_OFFSET, d);
      chk(d, 32'hD9D9);
      wr_reg(CTL01_OFFSET, 32'h0001);
      rd_reg(CTL01_OFFSET, d);
      chk(d, 32'h0001);
      @(posedge mclk);
      lock <= 2'b00;
      wr_reg(CTL01_OFFSET, 32'h0808);
      cmp_load(16'h0030);
      step(3);
      chk(act, 32'h00100010);
      @(posedge mclk);
      upd <= 1'b1;
      @(posedge mclk);
      upd <= 1'b0;
      step(2);
      chk(act, 32'h00300030);
      // Direction 11 relies on the trigger source being chosen outside this block
      wr_reg(CTL01_OFFSET, 32'h0000FFFF);
      rd_reg(CTL01_OFFSET, d);
      chk(d, 32'h0000FFFF);
      rd_reg(8'h1C, d);
      chk(d, 32'h0);
      step(1);
      chk(rdata, 32'h0);
      end_sim();
   end
endmodule : tocc_top_tb
`default_nettype wire
